//--- inc/usb_tok_pkg.sv
// ****************************************************************
// shared types and constants for the token decoder and ep2 path
// ****************************************************************
package usb_tok_pkg;

	// token pids as seen after the pid check bits are stripped
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hd;

	// address used before software assigns one
	localparam logic [6:0] DEFAULT_ADDR = 7'h00;

	// endpoints this device implements: 0, 1 (out) and 2 (in)
	localparam logic [3:0] EP_LAST = 4'h2;
	localparam logic [3:0] EP_RX = 4'h1;
	localparam logic [3:0] EP_TX = 4'h2;

	// underrun protection enable inside the device control register
	localparam int PROTECT_BIT = 7;

	// transmit fifo shape
	localparam int TX_FIFO_WIDTH = 8;
	localparam int TX_FIFO_DEPTH = 32;

	// crc constants, usb polynomials
	localparam logic [4:0] CRC5_INIT = 5'h1f;
	localparam logic [4:0] CRC5_POLY = 5'h05;
	localparam logic [15:0] CRC16_INIT = 16'hffff;
	localparam logic [15:0] CRC16_POLY = 16'h8005;
	// xor mask applied to the crc16 field of an underrun packet
	localparam logic [15:0] CRC16_SPOIL = 16'hffff;

	// reset values
	localparam logic [6:0] CNT_RESET = 7'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// one decoded token, fields in bus order (bit 0 first on the wire)
	typedef struct packed {
		logic [3:0] pid;
		logic [6:0] addr;
		logic [3:0] endp;
		logic [4:0] crc5;
	} token_t;

	// main sequencer
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OUT_DATA = 3'b001,
		ST_TX_DATA = 3'b010,
		ST_TX_CRC_LO = 3'b011,
		ST_TX_CRC_HI = 3'b100
	} seq_state_t;

	// crc5 field over address and endpoint, as it stands in the token
	function automatic logic [4:0] crc5_field(input logic [10:0] d);
		logic [4:0] c;
		logic [4:0] r;
		logic fb;
		c = CRC5_INIT;
		for (int i = 0; i < 11; i++) begin
			fb = d[i] ^ c[4];
			c = {c[3:0], 1'b0} ^ (fb ? CRC5_POLY : 5'h00);
		end
		c = ~c;
		for (int i = 0; i < 5; i++) begin
			r[i] = c[4 - i];
		end
		return r;
	endfunction

	// running crc16 over one byte, lsb first
	function automatic logic [15:0] crc16_step(input logic [15:0] c_in, input logic [7:0] d);
		logic [15:0] c;
		logic fb;
		c = c_in;
		for (int i = 0; i < 8; i++) begin
			fb = d[i] ^ c[15];
			c = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
		end
		return c;
	endfunction

	// crc16 field as sent, low byte first
	function automatic logic [15:0] crc16_field(input logic [15:0] c_in);
		logic [15:0] c;
		logic [15:0] r;
		c = ~c_in;
		for (int i = 0; i < 16; i++) begin
			r[i] = c[15 - i];
		end
		return r;
	endfunction

endpackage

//--- hw/tx_fifo.sv
`timescale 1ns/100ps
// ****************************************************************
// transmit fifo with registered read data and registered ready
// ****************************************************************
module tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	// all fifo state; the output word sits in its own register
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] cnt;
		logic in_ready;
		logic out_valid;
		logic [WIDTH-1:0] out_data;
	} fifo_state_t;

	fifo_state_t st_ff;
	fifo_state_t nxt_st;
	logic push;
	logic take;
	logic load;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		push = in_valid_i && st_ff.in_ready;
		take = st_ff.out_valid && out_ready_i;
		// refill the output register from memory whenever it frees up
		load = (st_ff.cnt != '0) && (!st_ff.out_valid || take);
		if (push) begin
			nxt_st.mem[st_ff.wptr] = in_data_i;
			nxt_st.wptr = st_ff.wptr + 1'b1;
		end
		if (load) begin
			nxt_st.out_data = st_ff.mem[st_ff.rptr];
			nxt_st.rptr = st_ff.rptr + 1'b1;
			nxt_st.out_valid = 1'b1;
		end else if (take) begin
			nxt_st.out_valid = 1'b0;
		end
		nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
		// flush drops everything, stored or in flight
		if (flush_i) begin
			nxt_st.wptr = '0;
			nxt_st.rptr = '0;
			nxt_st.cnt = '0;
			nxt_st.out_valid = 1'b0;
		end
		// ready is registered so the filling side sees a clean level
		nxt_st.in_ready = (nxt_st.cnt < (AW+1)'(DEPTH));
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_ff <= '0;
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	assign in_ready_o = st_ff.in_ready;
	assign out_valid_o = st_ff.out_valid;
	assign out_data_o = st_ff.out_data;
endmodule

//--- hw/usb_token_ep2.sv
`timescale 1ns/100ps
// ****************************************************************
// token decoder, endpoint 1 receive gate, endpoint 2 transmit path
// ****************************************************************

// How it works
// - answer only tokens carrying our address
// - address, endpoint and crc5 checked together
// - endpoint 1 out data only after matching token
// - before assignment only default address answered
// - unknown endpoint drops back to idle at once
// - fifo filled on request, sent after in
// - empty fifo resends the old byte unless control bit 7 set
// - underrun guard only while control bit 7 set
// - bytes popped one at a time from fifo
module usb_token_ep2 (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic bus_reset_i,
	input wire logic addr_set_i,
	input wire logic [6:0] dev_addr_i,
	input wire logic [7:0] usb_device_control_reg_i,
	input wire logic tok_valid_i,
	input wire usb_tok_pkg::token_t tok_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_eop_i,
	output logic tok_hit_o,
	output logic [3:0] tok_ep_o,
	output logic ep1_valid_o,
	output logic [7:0] ep1_data_o,
	output logic ep1_eop_o,
	input wire logic fill_valid_i,
	input wire logic [7:0] fill_data_i,
	output logic fill_ready_o,
	input wire logic [6:0] ep2_len_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	output logic underrun_o,
	input wire logic underrun_clr_i
);
	// whole block state in one record
	typedef struct packed {
		usb_tok_pkg::seq_state_t state;
		logic [6:0] addr; // address given by software
		logic addr_assigned; // low after bus reset
		logic [6:0] cnt; // bytes sent in this packet
		logic [15:0] crc16; // running crc of sent bytes
		logic spoil; // underrun seen in this packet
		logic [7:0] last_byte; // byte a legacy underrun repeats
		logic tok_hit;
		logic [3:0] tok_ep;
		logic ep1_valid;
		logic [7:0] ep1_data;
		logic ep1_eop;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_last;
		logic underrun;
	} blk_state_t;

	blk_state_t st_ff;
	blk_state_t nxt_st;

	logic fifo_valid; // fifo output word present
	logic [7:0] fifo_data; // fifo output word
	logic fifo_pop; // shifter takes the fifo word
	logic protect; // underrun guard enabled
	logic [6:0] cur_addr; // address we answer to now
	logic tok_addr_ok; // address field matches
	logic tok_crc_ok; // crc5 consistent with address and endpoint
	logic tok_ours; // whole token is for us
	logic [15:0] crc_out; // crc16 field to send

	// ****************************************************************
	// transmit fifo
	// ****************************************************************
	// flushed on bus reset, so a new host sees old data only as a legacy underrun repeat of last_byte
	tx_fifo #(
		.WIDTH(usb_tok_pkg::TX_FIFO_WIDTH),
		.DEPTH(usb_tok_pkg::TX_FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.flush_i(bus_reset_i),
		.in_valid_i(fill_valid_i),
		.in_data_i(fill_data_i),
		.in_ready_o(fill_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(fifo_pop)
	);

	// ****************************************************************
	// token match, all fields together
	// ****************************************************************
	always_comb begin
		// default address until software assigns one
		cur_addr = st_ff.addr_assigned ? st_ff.addr : usb_tok_pkg::DEFAULT_ADDR;
		tok_addr_ok = (tok_i.addr == cur_addr);
		// crc5 must agree with the received address and endpoint
		tok_crc_ok = (tok_i.crc5 == usb_tok_pkg::crc5_field({tok_i.endp, tok_i.addr}));
		tok_ours = tok_valid_i && tok_addr_ok && tok_crc_ok;
		protect = usb_device_control_reg_i[usb_tok_pkg::PROTECT_BIT];
		crc_out = usb_tok_pkg::crc16_field(st_ff.crc16) ^ (st_ff.spoil ? usb_tok_pkg::CRC16_SPOIL : 16'h0000);
		// one byte per shifter request, only while it is there
		fifo_pop = (st_ff.state == usb_tok_pkg::ST_TX_DATA) && tx_ready_i && fifo_valid;
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		// pulses last one cycle
		nxt_st.tok_hit = 1'b0;
		nxt_st.ep1_valid = 1'b0;
		nxt_st.ep1_eop = 1'b0;
		nxt_st.tx_valid = 1'b0;
		nxt_st.tx_last = 1'b0;
		// address capture from software
		if (addr_set_i) begin
			nxt_st.addr = dev_addr_i;
			nxt_st.addr_assigned = 1'b1;
		end
		case (st_ff.state)
			usb_tok_pkg::ST_IDLE,
			usb_tok_pkg::ST_OUT_DATA: begin
				// receive bytes pass only inside a matched ep1 out
				if (st_ff.state == usb_tok_pkg::ST_OUT_DATA && rx_valid_i) begin
					nxt_st.ep1_valid = 1'b1;
					nxt_st.ep1_data = rx_data_i;
				end
				if (st_ff.state == usb_tok_pkg::ST_OUT_DATA && rx_eop_i) begin
					nxt_st.ep1_eop = 1'b1;
					nxt_st.state = usb_tok_pkg::ST_IDLE;
				end
				// every valid token restarts decoding, never a wait
				if (tok_valid_i) begin
					nxt_st.state = usb_tok_pkg::ST_IDLE;
					if (tok_ours && tok_i.endp <= usb_tok_pkg::EP_LAST) begin
						nxt_st.tok_hit = 1'b1;
						nxt_st.tok_ep = tok_i.endp;
						if (tok_i.pid == usb_tok_pkg::PID_OUT && tok_i.endp == usb_tok_pkg::EP_RX) begin
							nxt_st.state = usb_tok_pkg::ST_OUT_DATA;
						end else if (tok_i.pid == usb_tok_pkg::PID_IN && tok_i.endp == usb_tok_pkg::EP_TX) begin
							// transmission starts only on an in token
							nxt_st.cnt = usb_tok_pkg::CNT_RESET;
							nxt_st.crc16 = usb_tok_pkg::CRC16_INIT;
							nxt_st.spoil = 1'b0;
							nxt_st.state = (ep2_len_i == usb_tok_pkg::CNT_RESET) ?
								usb_tok_pkg::ST_TX_CRC_LO : usb_tok_pkg::ST_TX_DATA;
						end
					end
				end
			end
			usb_tok_pkg::ST_TX_DATA: begin
				if (tx_ready_i) begin
					if (fifo_valid) begin
						// bottom word goes to the shifter
						nxt_st.tx_valid = 1'b1;
						nxt_st.tx_data = fifo_data;
						nxt_st.last_byte = fifo_data;
						nxt_st.crc16 = usb_tok_pkg::crc16_step(st_ff.crc16, fifo_data);
						nxt_st.cnt = st_ff.cnt + 7'h01;
						if (st_ff.cnt + 7'h01 == ep2_len_i) begin
							nxt_st.state = usb_tok_pkg::ST_TX_CRC_LO;
						end
					end else if (protect) begin
						// cut the packet short instead of resending
						// spoil the crc so the host retries
						nxt_st.spoil = 1'b1;
						nxt_st.state = usb_tok_pkg::ST_TX_CRC_LO;
					end else begin
						// guard off, the old byte goes out again
						nxt_st.tx_valid = 1'b1;
						nxt_st.tx_data = st_ff.last_byte;
						nxt_st.crc16 = usb_tok_pkg::crc16_step(st_ff.crc16, st_ff.last_byte);
						nxt_st.cnt = st_ff.cnt + 7'h01;
						if (st_ff.cnt + 7'h01 == ep2_len_i) begin
							nxt_st.state = usb_tok_pkg::ST_TX_CRC_LO;
						end
					end
				end
			end
			usb_tok_pkg::ST_TX_CRC_LO: begin
				if (tx_ready_i) begin
					nxt_st.tx_valid = 1'b1;
					nxt_st.tx_data = crc_out[7:0];
					nxt_st.state = usb_tok_pkg::ST_TX_CRC_HI;
				end
			end
			usb_tok_pkg::ST_TX_CRC_HI: begin
				if (tx_ready_i) begin
					nxt_st.tx_valid = 1'b1;
					nxt_st.tx_data = crc_out[15:8];
					nxt_st.tx_last = 1'b1;
					nxt_st.state = usb_tok_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_st.state = usb_tok_pkg::ST_IDLE;
			end
		endcase
		// sticky flag, a new underrun wins over the clear
		nxt_st.underrun = (st_ff.underrun && !underrun_clr_i) ||
			(st_ff.state == usb_tok_pkg::ST_TX_DATA && tx_ready_i && !fifo_valid && protect);
		// bus reset forgets the address and aborts any packet
		if (bus_reset_i) begin
			nxt_st.addr_assigned = 1'b0;
			nxt_st.state = usb_tok_pkg::ST_IDLE;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_ff <= '0;
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	assign tok_hit_o = st_ff.tok_hit;
	assign tok_ep_o = st_ff.tok_ep;
	assign ep1_valid_o = st_ff.ep1_valid;
	assign ep1_data_o = st_ff.ep1_data;
	assign ep1_eop_o = st_ff.ep1_eop;
	assign tx_valid_o = st_ff.tx_valid;
	assign tx_data_o = st_ff.tx_data;
	assign tx_last_o = st_ff.tx_last;
	assign underrun_o = st_ff.underrun;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i || !ce_i);

	a_foreign_addr_ignored: assert property (tok_valid_i && !tok_addr_ok |=> !tok_hit_o)
		else $error("token for another address was answered");
	a_crc_mismatch_ignored: assert property (tok_valid_i && !tok_crc_ok |=> !tok_hit_o)
		else $error("token with inconsistent crc5 was answered");
	a_ep1_gated_data: assert property (ep1_valid_o |-> $past(st_ff.state) == usb_tok_pkg::ST_OUT_DATA
		&& $past(rx_data_i) == ep1_data_o)
		else $error("endpoint 1 data passed outside a matched out");
	a_default_addr_only: assert property (!st_ff.addr_assigned && !addr_set_i && tok_valid_i
		&& tok_i.addr != usb_tok_pkg::DEFAULT_ADDR |=> !tok_hit_o && st_ff.state == usb_tok_pkg::ST_IDLE)
		else $error("unassigned device answered a non default address");
	a_bad_ep_resync: assert property (tok_ours && tok_i.endp > usb_tok_pkg::EP_LAST && !bus_reset_i
		&& (st_ff.state == usb_tok_pkg::ST_IDLE || st_ff.state == usb_tok_pkg::ST_OUT_DATA)
		|=> st_ff.state == usb_tok_pkg::ST_IDLE && !tok_hit_o)
		else $error("unknown endpoint left decoder waiting");
	a_tx_after_in: assert property ($rose(st_ff.state == usb_tok_pkg::ST_TX_DATA)
		|-> $past(tok_valid_i && tok_i.pid == usb_tok_pkg::PID_IN))
		else $error("transmission began without an in token");
	a_underrun_cut: assert property (fifo_valid == 1'b0 && protect && tx_ready_i && !bus_reset_i
		&& st_ff.state == usb_tok_pkg::ST_TX_DATA |=> !tx_valid_o && underrun_o
		&& st_ff.state == usb_tok_pkg::ST_TX_CRC_LO)
		else $error("guarded underrun did not cut the packet");
	a_guard_off_silent: assert property (!protect && !st_ff.underrun |=> !underrun_o)
		else $error("underrun flagged with guard off");
	a_pop_to_shifter: assert property (fifo_pop |=> tx_valid_o && tx_data_o == $past(fifo_data))
		else $error("popped fifo word did not reach the shifter");
	a_spoiled_crc: assert property (st_ff.state == usb_tok_pkg::ST_TX_CRC_HI && tx_ready_i && st_ff.spoil
		|=> tx_data_o == ~8'($past(usb_tok_pkg::crc16_field(st_ff.crc16) >> 8)) && tx_last_o)
		else $error("underrun packet sent with a good crc");

	c_ep1_packet: cover property (ep1_eop_o);
	c_in_packet: cover property (tx_last_o && !st_ff.spoil);
	c_underrun: cover property ($rose(underrun_o));
	c_bad_endpoint: cover property (tok_ours && tok_i.endp > usb_tok_pkg::EP_LAST);
endmodule

//--- bench/usb_host_model.sv
`timescale 1ns/100ps
// ****************************************************************
// host side of the link: tokens, out data and byte pulls
// ****************************************************************
module usb_host_model (
	input wire logic core_clk_i,
	output logic tok_valid_o,
	output usb_tok_pkg::token_t tok_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_eop_o,
	output logic tx_ready_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_last_i
);
	// everything idle at time zero
	initial begin
		tok_valid_o = 1'b0;
		tok_o = '0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		rx_eop_o = 1'b0;
		tx_ready_o = 1'b0;
	end

	// reflected crc5 over address then endpoint, own copy on purpose
	function automatic logic [4:0] tok_crc(input logic [10:0] d);
		logic [4:0] c;
		c = 5'h1f;
		for (int i = 0; i < 11; i++) begin
			c = ((c[0] ^ d[i]) == 1'b1) ? ((c >> 1) ^ 5'h14) : (c >> 1);
		end
		return ~c;
	endfunction

	// one token pulse; bad flips a crc bit
	task automatic send_token(input logic [3:0] pid, input logic [6:0] addr, input logic [3:0] endp,
			input logic bad);
		@(posedge core_clk_i);
		tok_valid_o <= 1'b1;
		tok_o <= {pid, addr, endp, tok_crc({endp, addr}) ^ {4'h0, bad}};
		@(posedge core_clk_i);
		tok_valid_o <= 1'b0;
		// a released field shows garbage, never the old token
		tok_o <= ~tok_o;
	endtask

	// data stage bytes, end of packet with the last one
	task automatic send_data(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= base + 8'(i);
			rx_eop_o <= (i == n - 1);
			@(posedge core_clk_i);
			rx_valid_o <= 1'b0;
			rx_eop_o <= 1'b0;
			rx_data_o <= ~rx_data_o;
		end
	endtask

	// bytes pulled only by host
	// gap idles first so slow hosts stall the fifo drain
	task automatic pull_byte(input int gap, output logic v, output logic [7:0] d, output logic l);
		repeat (gap) @(posedge core_clk_i);
		@(posedge core_clk_i);
		tx_ready_o <= 1'b1;
		@(posedge core_clk_i);
		tx_ready_o <= 1'b0;
		#1;
		v = tx_valid_i;
		d = tx_data_i;
		l = tx_last_i;
	endtask
endmodule

//--- bench/test_usb_device_token_decode_ep2_tx.sv
`timescale 1ns/100ps
// ****************************************************************
// self-checking bench for the token decoder and ep2 path
// ****************************************************************
module test_usb_device_token_decode_ep2_tx;
	logic core_clk_i, reset_n_i, ce_i, bus_reset_i, addr_set_i;
	logic [6:0] dev_addr_i, ep2_len_i, my_addr;
	logic [7:0] usb_device_control_reg_i, fill_data_i, rx_data, ep1_data_o, tx_data_o;
	logic tok_valid, rx_valid, rx_eop, tx_ready, fill_valid_i, underrun_clr_i;
	logic tok_hit_o, ep1_valid_o, ep1_eop_o, fill_ready_o, tx_valid_o, tx_last_o, underrun_o;
	logic [3:0] tok_ep_o;
	usb_tok_pkg::token_t tok;
	logic [7:0] ep1_q[$];
	int eop_seen, fail_count, checks_done, cycles;

	usb_token_ep2 dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.bus_reset_i(bus_reset_i), .addr_set_i(addr_set_i), .dev_addr_i(dev_addr_i),
		.usb_device_control_reg_i(usb_device_control_reg_i), .tok_valid_i(tok_valid), .tok_i(tok),
		.rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_eop_i(rx_eop), .tok_hit_o(tok_hit_o),
		.tok_ep_o(tok_ep_o), .ep1_valid_o(ep1_valid_o), .ep1_data_o(ep1_data_o), .ep1_eop_o(ep1_eop_o),
		.fill_valid_i(fill_valid_i), .fill_data_i(fill_data_i), .fill_ready_o(fill_ready_o),
		.ep2_len_i(ep2_len_i), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.tx_last_o(tx_last_o), .underrun_o(underrun_o), .underrun_clr_i(underrun_clr_i));

	usb_host_model host (.core_clk_i(core_clk_i), .tok_valid_o(tok_valid), .tok_o(tok),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_eop_o(rx_eop), .tx_ready_o(tx_ready),
		.tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o));

	// 200 mhz clock
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// ****************************************************************
	// monitors, timeout and reporting
	// ****************************************************************
	// ep1 pulses last one cycle, so they are caught at every edge
	always @(posedge core_clk_i) begin
		if (ep1_valid_o === 1'b1) begin
			ep1_q.push_back(ep1_data_o);
		end
		if (ep1_eop_o === 1'b1) begin
			eop_seen++;
		end
	end

	// hang guard, far beyond the few hundred cycles the run needs
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [7:0] pat(input int i);
		return 8'(i) ^ 8'h5a;
	endfunction

	// crc16 field over pat(0..n-1), reflected form, low byte sent first
	function automatic logic [15:0] crc_of(input int n);
		logic [15:0] c;
		logic [7:0] b;
		c = 16'hffff;
		for (int i = 0; i < n; i++) begin
			b = pat(i);
			for (int k = 0; k < 8; k++) begin
				c = ((c[0] ^ b[k]) == 1'b1) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return ~c;
	endfunction

	task automatic tok_expect(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] e, input logic bad,
			input logic hit);
		host.send_token(pid, a, e, bad);
		#1;
		check(tok_hit_o, hit);
		if (hit) begin
			check(tok_ep_o, e);
		end
	endtask

	// offer bytes until limit is reached or the fifo refuses for 4 edges
	task automatic fill_up(input int limit, output int n);
		int idle;
		n = 0;
		idle = 0;
		@(posedge core_clk_i);
		fill_valid_i <= 1'b1;
		fill_data_i <= pat(0);
		while (idle < 4 && n < limit) begin
			@(posedge core_clk_i);
			if (fill_ready_o === 1'b1) begin
				n++;
				fill_data_i <= pat(n);
				idle = 0;
			end else begin
				idle++;
			end
		end
		fill_valid_i <= 1'b0;
	endtask

	// in token, have data pulls from the fifo, then one starved pull if have is below len
	task automatic in_packet(input int len, input int have, input logic guard);
		logic v, l, ok;
		logic [7:0] d;
		logic [15:0] crc;
		crc = crc_of(have);
		ok = 1'b1;
		ep2_len_i <= 7'(len);
		usb_device_control_reg_i <= {guard, 7'h00};
		tok_expect(usb_tok_pkg::PID_IN, my_addr, 4'h2, 1'b0, 1'b1);
		for (int i = 0; i < have; i++) begin
			host.pull_byte(i % 3, v, d, l);
			check({v, d}, {1'b1, pat(i)});
		end
		if (have < len) begin
			host.pull_byte(0, v, d, l);
			if (guard) begin
				check(v, 1'b0);
				crc = ~crc;
			end else begin
				check(d, pat(have - 1));
				ok = 1'b0;
			end
			@(posedge core_clk_i);
			#1;
			check(underrun_o, guard);
		end
		host.pull_byte(1, v, d, l);
		if (ok) begin
			check(d, crc[7:0]);
		end
		host.pull_byte(0, v, d, l);
		if (ok) begin
			check(d, crc[15:8]);
		end
		check({v, l}, 2'b11);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic addr_phase;
		logic [6:0] oth_a[4];
		logic [3:0] oth_e[4];
		oth_a = '{7'h02, 7'h0d, 7'h06, 7'h00};
		oth_e = '{4'h1, 4'h1, 4'h1, 4'h0};
		tok_expect(usb_tok_pkg::PID_OUT, usb_tok_pkg::DEFAULT_ADDR, 4'h1, 1'b0, 1'b1);
		tok_expect(usb_tok_pkg::PID_OUT, 7'h0f, 4'h0, 1'b0, 1'b0);
		tok_expect(usb_tok_pkg::PID_OUT, usb_tok_pkg::DEFAULT_ADDR, 4'h1, 1'b1, 1'b0);
		@(posedge core_clk_i);
		addr_set_i <= 1'b1;
		dev_addr_i <= 7'h08;
		@(posedge core_clk_i);
		addr_set_i <= 1'b0;
		my_addr = 7'h08;
		tok_expect(usb_tok_pkg::PID_OUT, my_addr, 4'h1, 1'b0, 1'b1);
		tok_expect(usb_tok_pkg::PID_OUT, my_addr, 4'h1, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			tok_expect(usb_tok_pkg::PID_OUT, oth_a[i], oth_e[i], 1'b0, 1'b0);
		end
	endtask

	// unknown endpoints drop at once, the next good token hits
	task automatic ep_phase;
		logic [3:0] bad_e[3];
		bad_e = '{4'h3, 4'h5, 4'hf};
		for (int i = 0; i < 3; i++) begin
			tok_expect(usb_tok_pkg::PID_OUT, my_addr, bad_e[i], 1'b0, 1'b0);
			tok_expect(usb_tok_pkg::PID_OUT, my_addr, 4'h0, 1'b0, 1'b1);
		end
		// clock enable low freezes the decoder, so a good token goes unseen
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		tok_expect(usb_tok_pkg::PID_OUT, my_addr, 4'h0, 1'b0, 1'b0);
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		tok_expect(usb_tok_pkg::PID_OUT, my_addr, 4'h0, 1'b0, 1'b1);
	endtask

	task automatic out_phase;
		ep1_q.delete();
		eop_seen = 0;
		tok_expect(usb_tok_pkg::PID_OUT, 7'h02, 4'h1, 1'b0, 1'b0);
		host.send_data(2, 8'h10);
		tok_expect(usb_tok_pkg::PID_OUT, my_addr, 4'h1, 1'b0, 1'b1);
		host.send_data(3, 8'h20);
		repeat (2) @(posedge core_clk_i);
		check(ep1_q.size(), 3);
		for (int i = 0; i < ep1_q.size(); i++) begin
			check(ep1_q[i], 8'h20 + 8'(i));
		end
		check(eop_seen, 1);
	endtask

	// bus reset forgets the assigned address
	task automatic bus_reset_phase;
		@(posedge core_clk_i);
		bus_reset_i <= 1'b1;
		@(posedge core_clk_i);
		bus_reset_i <= 1'b0;
		my_addr = usb_tok_pkg::DEFAULT_ADDR;
		tok_expect(usb_tok_pkg::PID_OUT, 7'h08, 4'h1, 1'b0, 1'b0);
		tok_expect(usb_tok_pkg::PID_OUT, my_addr, 4'h1, 1'b0, 1'b1);
	endtask

	// fill until refused, no send before in, drain with stalls
	task automatic fifo_phase;
		int n;
		logic v, l;
		logic [7:0] d;
		fill_up(40, n);
		check(n, usb_tok_pkg::TX_FIFO_DEPTH + 1);
		host.pull_byte(0, v, d, l);
		check(v, 1'b0);
		in_packet(n, n, 1'b1);
		check(fill_ready_o, 1'b1);
		in_packet(0, 0, 1'b1);
	endtask

	// starved fifo with and without the guard bit
	task automatic underrun_phase;
		int n;
		fill_up(1, n);
		in_packet(3, 1, 1'b1);
		@(posedge core_clk_i);
		underrun_clr_i <= 1'b1;
		@(posedge core_clk_i);
		underrun_clr_i <= 1'b0;
		#1;
		check(underrun_o, 1'b0);
		fill_up(1, n);
		in_packet(2, 1, 1'b0);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		reset_n_i = 1'b0;
		ce_i = 1'b1;
		bus_reset_i = 1'b0;
		addr_set_i = 1'b0;
		dev_addr_i = 7'h00;
		usb_device_control_reg_i = 8'h00;
		fill_valid_i = 1'b0;
		fill_data_i = 8'h00;
		ep2_len_i = 7'h00;
		underrun_clr_i = 1'b0;
		my_addr = usb_tok_pkg::DEFAULT_ADDR;
		repeat (4) @(posedge core_clk_i);
		check({tok_hit_o, ep1_valid_o, tx_valid_o, underrun_o, fill_ready_o}, 5'h00);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1;
		check(fill_ready_o, 1'b1);
		addr_phase();
		ep_phase();
		out_phase();
		bus_reset_phase();
		fifo_phase();
		underrun_phase();
		give_verdict();
	end
endmodule
